// *** crc_pkg.sv ***
`default_nettype none
package crc_pkg;
    // ************************************************************
    // Card geometry
    // ************************************************************
    localparam int COLS_PER_HALF  = 45;
    localparam int ROWS_PER_HALF  = 6;
    localparam int ROWS_PER_CARD  = 12;
    localparam int FIRST_TOP_COL  = 1;
    localparam int FIRST_BOT_COL  = 46;
    localparam int LAST_COL       = 90;
    localparam int WORDS_PER_HALF = 5;
    localparam int WORD_DIGITS    = 10;
    localparam int LAST_WORD_DIGS = 5;
    // ************************************************************
    // Processor instruction codes
    // ************************************************************
    localparam logic [6:0] OP_FEED    = 7'h48;  // 72
    localparam logic [6:0] OP_STACKER = 7'h2F;  // 47
    localparam logic [6:0] OP_MOVE    = 7'h60;  // 96
    localparam logic [1:0] STACKER_DEFAULT = 2'h0;
    localparam logic [1:0] STACKER_COUNT   = 2'h3;
    // ************************************************************
    // Station and buffer write codes
    // ************************************************************
    localparam logic       ST_ONE = 1'h0;
    localparam logic       ST_TWO = 1'h1;
    localparam logic [3:0] ROW_LAST = 4'hB;
    // Sequencer states
    typedef enum logic [4:0] {
        CRC_IDLE  = 5'b00001,
        CRC_FEED  = 5'b00010,
        CRC_SENSE = 5'b00100,
        CRC_WR1   = 5'b01000,
        CRC_WR2   = 5'b10000
    } crc_state_e;
endpackage
`default_nettype wire

// *** crc_card_row_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
module crc_card_row_capture #(
    parameter int COLS = 45
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Processor instruction port
    input  wire logic             instr_valid,
    input  wire logic [6:0]       instr_code,
    input  wire logic [1:0]       instr_stacker,
    output logic                  instr_busy,
    // Reader pins
    input  wire logic             row_strobe,
    input  wire logic             card_at_st1,
    input  wire logic [COLS-1:0]  brush_st1,
    input  wire logic [COLS-1:0]  brush_st2,
    output logic                  sense_pulse,
    output logic                  feed_card,
    output logic [1:0]            stacker_sel,
    output logic                  stacker_go,
    output logic                  empty_lamp,
    // Card buffer band writes
    output logic                  buf_wr,
    output logic                  buf_station,
    output logic                  buf_half,
    output logic [2:0]            buf_bit,
    output logic [COLS-1:0]       buf_data,
    output logic                  st2_data_valid,
    output logic                  move_to_main
);
    import crc_pkg::*;

    // Only the 45-brush row is served; row latches and band words share this width
    if (COLS != COLS_PER_HALF) begin : g_cols_check
        $error("COLS must be 45");
    end

    // Decode one column's six punches, ordered 9,7,5,3,1,0; 4'hF when invalid
    // Reference decode for the program side; the band itself keeps raw punch bits
    function automatic logic [3:0] col_digit(input logic [5:0] p);
        logic [3:0] d;
        d = 4'hF;
        case (p)
            6'b000001: d = 4'h0;
            6'b000010: d = 4'h1;
            6'b000100: d = 4'h3;
            6'b001000: d = 4'h5;
            6'b010000: d = 4'h7;
            6'b100000: d = 4'h9;
            6'b100010: d = 4'h2;
            6'b100100: d = 4'h4;
            6'b101000: d = 4'h6;
            6'b110000: d = 4'h8;
            default:   d = 4'hF;
        endcase
        return d;
    endfunction

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic            strobe_d;

    // Brushes pass two flops before the row latch reads them
    // The brush bus needs no handshake: brushes settle before the strobe rises
    // and pass the same two stages, so the latched row is coherent
    logic [COLS-1:0] b1_a;
    logic [COLS-1:0] b1_b;
    logic [COLS-1:0] b2_a;
    logic [COLS-1:0] b2_b;
    logic            strb_a;
    logic            strb_b;
    logic            card_a;
    logic            card_b;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            b1_a     <= '0;
            b1_b     <= '0;
            b2_a     <= '0;
            b2_b     <= '0;
            strb_a   <= 1'b0;
            strb_b   <= 1'b0;
            card_a   <= 1'b0;
            card_b   <= 1'b0;
            strobe_d <= 1'b0;
        end else begin
            b1_a     <= brush_st1;
            b1_b     <= b1_a;
            b2_a     <= brush_st2;
            b2_b     <= b2_a;
            strb_a   <= row_strobe;
            strb_b   <= strb_a;
            card_a   <= card_at_st1;
            card_b   <= card_a;
            strobe_d <= strb_b;
        end
    end

    // Strobe idles low and its delay flop resets low, so reset makes no false edge
    logic strobe_rise;
    assign strobe_rise = strb_b & ~strobe_d;

    // ************************************************************
    // Sequencer
    // ************************************************************
    crc_state_e       state;
    crc_state_e       next_state;
    logic [3:0]       row_idx;
    logic [3:0]       next_row_idx;
    logic [COLS-1:0]  hold1;
    logic [COLS-1:0]  next_hold1;
    logic [COLS-1:0]  hold2;
    logic [COLS-1:0]  next_hold2;
    logic             saw_card;
    logic             next_saw_card;
    logic             st2_loaded;
    logic             next_st2_loaded;
    logic [1:0]       stk_sel;
    logic [1:0]       next_stk_sel;
    logic             next_instr_busy;
    logic             next_sense_pulse;
    logic             next_feed_card;
    logic             next_stacker_go;
    logic             next_empty_lamp;
    logic             next_buf_wr;
    logic             next_buf_station;
    logic             next_buf_half;
    logic [2:0]       next_buf_bit;
    logic [COLS-1:0]  next_buf_data;
    logic             next_st2_data_valid;
    logic             next_move_to_main;
    logic             recorded;
    logic             next_recorded;

    // Next-state logic: one row cycle latches both stations, then writes each
    always_comb begin
        next_state          = state;
        next_row_idx        = row_idx;
        next_hold1          = hold1;
        next_hold2          = hold2;
        next_saw_card       = saw_card;
        next_st2_loaded     = st2_loaded;
        next_stk_sel        = stk_sel;
        next_recorded       = recorded;
        next_instr_busy     = 1'b0;
        next_sense_pulse    = 1'b0;
        next_feed_card      = 1'b0;
        next_stacker_go     = 1'b0;
        next_empty_lamp     = empty_lamp;
        next_buf_wr         = 1'b0;
        next_buf_station    = buf_station;
        next_buf_half       = buf_half;
        next_buf_bit        = buf_bit;
        next_buf_data       = buf_data;
        next_st2_data_valid = st2_data_valid;
        next_move_to_main   = 1'b0;
        // Stacker choice may arrive at any time; out-of-range codes ignored
        if (instr_valid && instr_code == OP_STACKER && instr_stacker < STACKER_COUNT)
            next_stk_sel = instr_stacker;
        // Move to main only once both stations' cards are fully in the band
        if (instr_valid && instr_code == OP_MOVE && recorded && state == CRC_IDLE) begin
            next_move_to_main = 1'b1;
            next_recorded     = 1'b0;
        end
        case (state)
            CRC_IDLE: begin
                if (instr_valid && instr_code == OP_FEED && !empty_lamp) begin
                    next_feed_card  = 1'b1;
                    next_saw_card   = 1'b0;
                    next_row_idx    = 4'h0;
                    next_recorded   = 1'b0;
                    next_instr_busy = 1'b1;
                    next_state      = CRC_FEED;
                end
            end
            CRC_FEED: begin
                next_state = CRC_SENSE;
            end
            CRC_SENSE: begin
                // Card presence is remembered over the whole card, not at one row
                if (card_b)
                    next_saw_card = 1'b1;
                if (strobe_rise) begin
                    // Pulse the roll and latch one row of each station
                    next_sense_pulse = 1'b1;
                    next_hold1       = b1_b;
                    next_hold2       = b2_b;
                    next_state       = CRC_WR1;
                end
            end
            CRC_WR1: begin
                // Half and bit index follow the row count; bit 0 first
                next_buf_wr      = 1'b1;
                next_buf_station = ST_ONE;
                next_buf_half    = (row_idx >= 4'(ROWS_PER_HALF));
                next_buf_bit     = 3'(row_idx >= 4'(ROWS_PER_HALF)
                                      ? row_idx - 4'(ROWS_PER_HALF) : row_idx);
                next_buf_data    = hold1;
                next_hold1       = '0;
                next_state       = CRC_WR2;
            end
            CRC_WR2: begin
                next_buf_wr         = 1'b1;
                next_buf_station    = ST_TWO;
                next_buf_data       = hold2;
                next_st2_data_valid = st2_loaded;
                next_hold2          = '0;
                // Routing fires only when station two holds a real earlier card
                if (row_idx == ROW_LAST) begin
                    next_st2_loaded  = 1'b1;
                    next_stacker_go  = st2_loaded;
                    next_recorded    = 1'b1;
                    next_state       = CRC_IDLE;
                    if (!saw_card && !card_b)
                        next_empty_lamp = 1'b1;
                end else begin
                    next_row_idx = row_idx + 4'h1;
                    next_state   = CRC_SENSE;
                end
            end
            default: next_state = CRC_IDLE;
        endcase
        // Busy mirrors the next state, so busy and the refusal of a feed disagree only while the empty lamp is lit
        next_instr_busy = (next_state != CRC_IDLE);
    end

    // State registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state          <= CRC_IDLE;
            row_idx        <= 4'h0;
            hold1          <= '0;
            hold2          <= '0;
            saw_card       <= 1'b0;
            st2_loaded     <= 1'b0;
            stk_sel        <= STACKER_DEFAULT;
            recorded       <= 1'b0;
            instr_busy     <= 1'b0;
            sense_pulse    <= 1'b0;
            feed_card      <= 1'b0;
            stacker_sel    <= STACKER_DEFAULT;
            stacker_go     <= 1'b0;
            empty_lamp     <= 1'b0;
            buf_wr         <= 1'b0;
            buf_station    <= ST_ONE;
            buf_half       <= 1'b0;
            buf_bit        <= 3'h0;
            buf_data       <= '0;
            st2_data_valid <= 1'b0;
            move_to_main   <= 1'b0;
        end else begin
            state          <= next_state;
            row_idx        <= next_row_idx;
            hold1          <= next_hold1;
            hold2          <= next_hold2;
            saw_card       <= next_saw_card;
            st2_loaded     <= next_st2_loaded;
            stk_sel        <= next_stk_sel;
            recorded       <= next_recorded;
            instr_busy     <= next_instr_busy;
            sense_pulse    <= next_sense_pulse;
            feed_card      <= next_feed_card;
            stacker_sel    <= next_stk_sel;
            stacker_go     <= next_stacker_go;
            empty_lamp     <= next_empty_lamp;
            buf_wr         <= next_buf_wr;
            buf_station    <= next_buf_station;
            buf_half       <= next_buf_half;
            buf_bit        <= next_buf_bit;
            buf_data       <= next_buf_data;
            st2_data_valid <= next_st2_data_valid;
            move_to_main   <= next_move_to_main;
        end
    end

    // Word grouping per half: columns 1-10,11-20,21-30,31-40 then 41-45
    // The drum side applies this layout; the band rows stay column ordered
    function automatic logic [2:0] col_word(input logic [5:0] col);
        return 3'(col / 6'(WORD_DIGITS));
    endfunction

endmodule
`default_nettype wire

// *** crc_capture_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Port checker for the row capture block
// ************************************************************
module crc_capture_chk
    import crc_pkg::*;
#(
    parameter int COLS = 45
) (
    // Clock and reset
    input wire logic            clock,
    input wire logic            sys_rst,
    // Instructions
    input wire logic            instr_valid,
    input wire logic [6:0]      instr_code,
    input wire logic [1:0]      instr_stacker,
    input wire logic            instr_busy,
    // Reader and buffer side
    input wire logic            sense_pulse,
    input wire logic            feed_card,
    input wire logic [1:0]      stacker_sel,
    input wire logic            stacker_go,
    input wire logic            empty_lamp,
    input wire logic            buf_wr,
    input wire logic            buf_station,
    input wire logic            buf_half,
    input wire logic [2:0]      buf_bit,
    input wire logic [COLS-1:0] buf_data,
    input wire logic            move_to_main
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Instruction answers and refusals
    a_feed_answer: assert property (
        instr_valid && instr_code == OP_FEED && !instr_busy && !empty_lamp |=> feed_card)
        else $error("Feed instruction not answered");
    a_feed_refused: assert property (
        instr_valid && instr_code == OP_FEED && (instr_busy || empty_lamp) |=> !feed_card)
        else $error("Feed accepted while busy or empty");
    a_stack_pick: assert property (
        instr_valid && instr_code == OP_STACKER && instr_stacker != 2'h3 |=> stacker_sel == $past(instr_stacker))
        else $error("Stacker choice not taken");
    a_move_refused: assert property (
        instr_valid && instr_code == OP_MOVE && instr_busy |=> !move_to_main)
        else $error("Move accepted during a card");
    a_pulse_single: assert property (
        feed_card || move_to_main |=> !feed_card && !move_to_main)
        else $error("Answer pulse longer than one cycle");
    // Row traffic into the buffer band, and the empty lamp hold
    a_pair_order: assert property (
        buf_wr && buf_station == ST_ONE |=> buf_wr && buf_station == ST_TWO && $stable(buf_bit) && $stable(buf_half))
        else $error("Station pair not written back to back");
    a_sense_write: assert property (
        sense_pulse |=> buf_wr && buf_station == ST_ONE)
        else $error("Sensed row not written next cycle");
    a_row_range: assert property (
        buf_wr |-> buf_bit <= 3'h5)
        else $error("Row bit outside six rows");
    a_empty_hold: assert property (
        empty_lamp |=> empty_lamp)
        else $error("Empty indication dropped");
    c_feed: cover property (feed_card);
    c_move: cover property (move_to_main);
    c_go: cover property (stacker_go);
    c_empty: cover property ($rose(empty_lamp));
endmodule
bind crc_card_row_capture crc_capture_chk #(.COLS(COLS)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_code(instr_code),
    .instr_stacker(instr_stacker), .instr_busy(instr_busy), .sense_pulse(sense_pulse),
    .feed_card(feed_card), .stacker_sel(stacker_sel), .stacker_go(stacker_go),
    .empty_lamp(empty_lamp), .buf_wr(buf_wr), .buf_station(buf_station), .buf_half(buf_half),
    .buf_bit(buf_bit), .buf_data(buf_data), .move_to_main(move_to_main));
`default_nettype wire

// *** crc_proc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Processor and drum buffer band model
// ************************************************************
module crc_proc_model
    import crc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Instruction port
    output logic             instr_valid,
    output logic [6:0]       instr_code,
    output logic [1:0]       instr_stacker,
    // Buffer band writes
    input  wire logic        buf_wr,
    input  wire logic        buf_station,
    input  wire logic        buf_half,
    input  wire logic [2:0]  buf_bit,
    input  wire logic [44:0] buf_data
);
    logic [44:0] band [2][12];
    int          wr_count;
    initial begin
        instr_valid   = 1'h0;
        instr_code    = 7'h7F;
        instr_stacker = 2'h3;
    end
    // One-cycle strobe; code lines show garbage once released, as a real bus would
    task automatic issue(input logic [6:0] code, input logic [1:0] stk);
        @(negedge clock);
        instr_valid   = 1'h1;
        instr_code    = code;
        instr_stacker = stk;
        @(negedge clock);
        instr_valid   = 1'h0;
        instr_code    = ~code;
        instr_stacker = ~stk;
    endtask
    // Each station keeps its own rows so both readings stay comparable
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_count <= 0;
        end else if (buf_wr) begin
            band[buf_station][int'(buf_half) * 6 + int'(buf_bit)] <= buf_data;
            wr_count <= wr_count + 1;
        end
    end
endmodule
`default_nettype wire

// *** crc_card_row_capture_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module crc_card_row_capture_bench;
    import crc_pkg::*;
    localparam int LIMIT = 5000; // Four cards need well under a thousand cycles
    logic        clock, sys_rst, row_strobe, card_at_st1, go_seen;
    logic [44:0] brush_st1, brush_st2, buf_data;
    logic        instr_valid, instr_busy, sense_pulse, feed_card, stacker_go, empty_lamp;
    logic        buf_wr, buf_station, buf_half, st2_data_valid, move_to_main;
    logic [6:0]  instr_code;
    logic [1:0]  instr_stacker, stacker_sel;
    logic [2:0]  buf_bit;
    int          fail_count, checks, cycles;
    crc_card_row_capture dut (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_code(instr_code), .instr_stacker(instr_stacker), .instr_busy(instr_busy),
        .row_strobe(row_strobe), .card_at_st1(card_at_st1), .brush_st1(brush_st1),
        .brush_st2(brush_st2), .sense_pulse(sense_pulse), .feed_card(feed_card),
        .stacker_sel(stacker_sel), .stacker_go(stacker_go), .empty_lamp(empty_lamp),
        .buf_wr(buf_wr), .buf_station(buf_station), .buf_half(buf_half), .buf_bit(buf_bit),
        .buf_data(buf_data), .st2_data_valid(st2_data_valid), .move_to_main(move_to_main));
    crc_proc_model proc (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_code(instr_code), .instr_stacker(instr_stacker), .buf_wr(buf_wr),
        .buf_station(buf_station), .buf_half(buf_half), .buf_bit(buf_bit), .buf_data(buf_data));
    initial clock = 1'h0;
    always #20 clock = ~clock;
    // Latch the routing pulse so it is not missed between polls
    always @(negedge clock) if (stacker_go === 1'h1) go_seen = 1'h1;
    task automatic conclude();
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            $display("Error timeout expected below %0d seen %0d", LIMIT, cycles);
            conclude();
        end
    end
    task automatic check_flag(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_word(input string what, input logic [44:0] exp, input logic [44:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Distinct per row and card; both end columns toggle to expose order slips
    function automatic logic [44:0] pat(input int r, input int c);
        return (45'h1 << (r + c * 7)) | {c[0] ^ r[0], 43'h0, ~c[0]};
    endfunction
    // Station two holds the previous card, as in continuous feeding
    task automatic do_row(input int r, input int c, input bit chk);
        int n;
        @(negedge clock);
        brush_st1  = pat(r, c + 1);
        brush_st2  = pat(r, c);
        row_strobe = 1'h1;
        for (n = 0; n < 12 && buf_wr !== 1'h1; n++) @(negedge clock);
        if (chk) begin
            check_flag("st1 write", 1'h1, buf_wr && buf_station == ST_ONE);
            check_flag("half", r >= 6, buf_half);
            check_word("bit", 45'(r % 6), 45'(buf_bit));
            check_word("st1 row", pat(r, c + 1), buf_data);
        end
        @(negedge clock);
        if (chk) begin
            check_flag("st2 write", 1'h1, buf_wr && buf_station == ST_TWO);
            check_word("st2 row", pat(r, c), buf_data);
            check_flag("st2 valid", c > 0, st2_data_valid);
        end
        row_strobe = 1'h0;
        brush_st1  = ~brush_st1;
        brush_st2  = ~brush_st2;
        repeat (4) @(negedge clock);
    endtask
    task automatic run_card(input int c, input bit present, input logic [6:0] mid);
        int r;
        go_seen     = 1'h0;
        card_at_st1 = present;
        proc.issue(OP_FEED, 2'h0);
        check_flag("feed pulse", 1'h1, feed_card);
        for (r = 0; r < 12; r++) begin
            if (r == 6) begin
                proc.issue(mid, 2'h3);
                check_flag("mid pulse", 1'h0, feed_card | move_to_main);
            end
            do_row(r, c, present);
        end
        card_at_st1 = 1'h0;
        for (r = 0; r < 20 && instr_busy !== 1'h0; r++) @(negedge clock);
        repeat (2) @(negedge clock);
        if (present) begin
            check_flag("busy end", 1'h0, instr_busy);
            check_flag("stacker go", c > 0, go_seen);
        end
    endtask
    task automatic test_route_first();
        proc.issue(OP_MOVE, 2'h0);
        check_flag("early move", 1'h0, move_to_main);
        proc.issue(OP_STACKER, 2'h2);
        @(negedge clock);
        check_word("stacker", 45'h2, {43'h0, stacker_sel});
        run_card(0, 1'h1, OP_FEED);
        $display("test_route_first done");
    endtask
    task automatic test_refusals();
        run_card(1, 1'h1, OP_MOVE);
        proc.issue(OP_MOVE, 2'h0);
        check_flag("move pulse", 1'h1, move_to_main);
        run_card(2, 1'h1, OP_STACKER);
        check_word("stacker kept", 45'h2, {43'h0, stacker_sel});
        check_word("drum writes", 45'h48, 45'(proc.wr_count));
        check_word("band st1", pat(0, 3), proc.band[0][0]);
        check_word("band st2", pat(11, 2), proc.band[1][11]);
        $display("test_refusals done");
    endtask
    task automatic test_empty_bin();
        run_card(3, 1'h0, OP_FEED);
        check_flag("empty lamp", 1'h1, empty_lamp);
        proc.issue(OP_FEED, 2'h0);
        check_flag("feed when empty", 1'h0, feed_card);
        $display("test_empty_bin done");
    endtask
    initial begin
        sys_rst     = 1'h1;
        row_strobe  = 1'h0;
        card_at_st1 = 1'h0;
        brush_st1   = 45'h0;
        brush_st2   = 45'h0;
        go_seen     = 1'h0;
        fail_count  = 0;
        checks      = 0;
        cycles      = 0;
        repeat (4) @(negedge clock);
        sys_rst = 1'h0;
        test_route_first();
        test_refusals();
        test_empty_bin();
        conclude();
    end
endmodule
`default_nettype wire
